// >>> hdl/dli_initiator.sv
// Die link initiator end with APB command port.
`timescale 1ns/10ps
`default_nettype none
`include "dli_defines.svh"
module dli_initiator
  import dli_pkg::*;
(
  // System
  input  wire logic        clock,
  input  wire logic        rstn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Link pins
  dli_if.initiator         link,
  output logic             irq_level
);

  dli_ini_state_t state_reg;
  logic [3:0]  ph_reg;
  logic        clk_reg;
  logic [27:0] tx_reg;
  logic [3:0]  cmd_reg;
  logic [3:0]  tx_left_reg;
  logic [3:0]  rise_left_reg;
  logic        oe_reg;
  logic [19:0] rx_reg;
  logic [15:0] rdata_reg;
  logic        done_reg;
  logic        err_reg;
  logic        word_reg;
  logic [5:0]  gap_reg;
  logic [3:0]  d_s1_reg;
  logic [3:0]  d_s2_reg;
  logic        irq_s1_reg;
  logic        irq_s2_reg;
  logic        acc;
  logic        win_blk;
  logic        win_nb;
  logic        reg_hit;
  logic        idle;
  logic        start;
  logic        tick;
  logic [3:0]  new_cmd;

  // ==========================================================
  // APB decode
  assign acc = psel & penable;
  assign win_blk = (paddr[11:8] == `DLI_BLK_WIN);
  assign win_nb = (paddr[11:8] == `DLI_NB_WIN);
  assign reg_hit = (paddr == `DLI_CFG_OFF) || (paddr == `DLI_STAT_OFF);
  assign idle = (state_reg == DLI_ST_IDLE);

  always_comb begin
    new_cmd = DLI_CMD_NONE;
    if (win_nb) begin
      new_cmd = word_reg ? DLI_CMD_WRW_NB : DLI_CMD_WRB_NB;
    end else if (win_blk && pwrite) begin
      new_cmd = word_reg ? DLI_CMD_WRW_BL : DLI_CMD_WRB_BL;
    end else if (win_blk) begin
      new_cmd = word_reg ? DLI_CMD_RDW : DLI_CMD_RDB;
    end else if (pwrite && pwdata[`DLI_CFG_WAKE]) begin
      new_cmd = DLI_CMD_WAKE;
    end
  end

  assign start = acc & idle & ((win_blk & ~done_reg) | (win_nb & pwrite) |
                 (pwrite & (paddr == `DLI_CFG_OFF) & pwdata[`DLI_CFG_WAKE]));
  assign pready = win_blk ? done_reg : ((win_nb & pwrite) ? idle : 1'b1);
  assign pslverr = (win_nb & ~pwrite) | (~win_blk & ~win_nb & ~reg_hit) |
                   (win_blk & done_reg & err_reg);

  always_comb begin
    prdata = 32'h00000000;
    if (win_blk) begin
      prdata = {16'h0000, rdata_reg};
    end else if (paddr == `DLI_CFG_OFF) begin
      prdata = {31'h00000000, word_reg};
    end else if (paddr == `DLI_STAT_OFF) begin
      prdata = {29'h00000000, irq_s2_reg, err_reg, ~idle};
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      word_reg <= 1'b0;
    end else if (acc && pwrite && paddr == `DLI_CFG_OFF) begin
      word_reg <= pwdata[`DLI_CFG_WORD];
    end
  end

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge clock) begin
    if (!rstn) begin
      d_s1_reg   <= 4'h0;
      d_s2_reg   <= 4'h0;
      irq_s1_reg <= 1'b0;
      irq_s2_reg <= 1'b0;
    end else begin
      d_s1_reg   <= link.link_data_pins;
      d_s2_reg   <= d_s1_reg;
      irq_s1_reg <= link.link_irq_pin;
      irq_s2_reg <= irq_s1_reg;
    end
  end

  // ==========================================================
  // Frame engine; link clock from a divider, idle low
  assign tick = (ph_reg == 4'(`DLI_HALF_CYC - 1));

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_reg     <= DLI_ST_IDLE;
      ph_reg        <= 4'h0;
      clk_reg       <= 1'b0;
      tx_reg        <= 28'h0000000;
      cmd_reg       <= 4'h0;
      tx_left_reg   <= 4'h0;
      rise_left_reg <= 4'h0;
      oe_reg        <= 1'b0;
      rx_reg        <= 20'h00000;
      gap_reg       <= 6'h00;
    end else begin
      unique case (state_reg)
        DLI_ST_IDLE: begin
          if (start) begin
            tx_reg        <= {new_cmd, paddr[7:0], word_reg ? pwdata[15:0] :
                              {pwdata[7:0], 8'h00}};
            cmd_reg       <= new_cmd;
            tx_left_reg   <= req_nibs(new_cmd);
            rise_left_reg <= req_nibs(new_cmd) + rsp_nibs(new_cmd);
            oe_reg        <= 1'b1;
            ph_reg        <= 4'h0;
            state_reg     <= DLI_ST_RUN;
          end
        end
        DLI_ST_RUN: begin
          ph_reg <= tick ? 4'h0 : ph_reg + 4'h1;
          if (tick) begin
            clk_reg <= ~clk_reg;
            if (!clk_reg) begin
              rise_left_reg <= rise_left_reg - 4'h1;
              if (!oe_reg) begin
                rx_reg <= {rx_reg[15:0], d_s2_reg};
              end
            end else begin
              tx_reg      <= {tx_reg[23:0], 4'h0};
              tx_left_reg <= (tx_left_reg != 4'h0) ? tx_left_reg - 4'h1 : 4'h0;
              oe_reg      <= (tx_left_reg > 4'h1);
              if (rise_left_reg == 4'h0) begin
                gap_reg   <= 6'h00;
                state_reg <= DLI_ST_GAP;
              end
            end
          end
        end
        DLI_ST_GAP: begin
          // Quiet time lets the target re-arm its frame
          gap_reg <= gap_reg + 6'h01;
          if (gap_reg == `DLI_GAP_CYC) begin
            state_reg <= DLI_ST_IDLE;
          end
        end
        default: state_reg <= DLI_ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Completion of blocking accesses
  always_ff @(posedge clock) begin
    if (!rstn) begin
      done_reg  <= 1'b0;
      err_reg   <= 1'b0;
      rdata_reg <= 16'h0000;
    end else if (state_reg == DLI_ST_RUN && tick && clk_reg &&
                 rise_left_reg == 4'h0) begin
      done_reg <= cmd_block(cmd_reg);
      err_reg  <= cmd_block(cmd_reg) &
                  (rx_reg[`DLI_ST_ERR] | ~rx_reg[`DLI_ST_END]);
      if (cmd_read(cmd_reg)) begin
        rdata_reg <= cmd_word(cmd_reg) ? rx_reg[19:4] : {8'h00, rx_reg[11:4]};
      end
    end else if (acc && win_blk && done_reg) begin
      done_reg <= 1'b0;
    end
  end

  assign link.link_clock_pin = clk_reg;
  assign link.ini_data_out = tx_reg[27:24];
  assign link.ini_data_oe = oe_reg;
  assign irq_level = irq_s2_reg;

endmodule
`default_nettype wire

// >>> hdl/dli_target.sv
// Die link target end with interrupt source mirror.
`timescale 1ns/10ps
`default_nettype none
`include "dli_defines.svh"
module dli_target
  import dli_pkg::*;
(
  // System
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire dli_mode_t   mode,
  // Link pins
  dli_if.target            link,
  // Interrupt sources
  input  wire logic [4:0]  volt_cond,
  input  wire logic [12:0] src_irq,
  input  wire logic        die_wake,
  output logic             wake_event,
  // Peripheral access
  output logic [7:0]       per_addr,
  output logic [15:0]      per_wdata,
  output logic             per_word,
  output logic             per_wr,
  output logic             per_rd,
  input  wire logic [15:0] per_rdata
);

  logic        clk_s1_reg;
  logic        clk_s2_reg;
  logic        clk_s3_reg;
  logic [3:0]  dat_s1_reg;
  logic [3:0]  dat_s2_reg;
  logic [3:0]  nib_reg;
  logic [3:0]  cmd_reg;
  logic [7:0]  addr_reg;
  logic [15:0] wdata_reg;
  logic        done_reg;
  logic [5:0]  idle_reg;
  logic        exec_reg;
  logic [23:0] resp_reg;
  logic [3:0]  left_reg;
  logic        drive_reg;
  logic [3:0]  out_reg;
  logic [4:0]  vcond_reg;
  logic [4:0]  vlatch_reg;
  logic        wake_reg;
  logic        wake_ev_reg;
  logic        irq_reg;
  logic        rise;
  logic        fall;
  logic        link_en;
  logic        idle_out;
  logic [3:0]  cur_cmd;
  logic        last;
  logic        hit_mirror;
  logic        hit_volt;
  logic        wr_err;
  logic [3:0]  st;
  logic [15:0] mirror;
  logic [15:0] rd_val;
  logic        volt_clr;

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge clock) begin
    if (!rstn) begin
      clk_s1_reg <= 1'b0;
      clk_s2_reg <= 1'b0;
      clk_s3_reg <= 1'b0;
      dat_s1_reg <= 4'h0;
      dat_s2_reg <= 4'h0;
    end else begin
      clk_s1_reg <= link.link_clock_pin;
      clk_s2_reg <= clk_s1_reg;
      clk_s3_reg <= clk_s2_reg;
      dat_s1_reg <= link.link_data_pins;
      dat_s2_reg <= dat_s1_reg;
    end
  end

  assign rise = clk_s2_reg & ~clk_s3_reg;
  assign fall = ~clk_s2_reg & clk_s3_reg;
  assign link_en = (mode != DLI_SLEEP);
  assign idle_out = (idle_reg == `DLI_IDLE_CYC);
  assign cur_cmd = (nib_reg == 4'h0) ? dat_s2_reg : cmd_reg;
  assign last = rise & ~done_reg & ((nib_reg + 4'h1) == req_nibs(cur_cmd));

  // ==========================================================
  // Request capture
  always_ff @(posedge clock) begin
    if (!rstn || !link_en) begin
      nib_reg   <= 4'h0;
      cmd_reg   <= 4'h0;
      addr_reg  <= 8'h00;
      wdata_reg <= 16'h0000;
      done_reg  <= 1'b0;
      idle_reg  <= 6'h00;
    end else begin
      if (rise || fall) begin
        idle_reg <= 6'h00;
      end else if (!idle_out) begin
        idle_reg <= idle_reg + 6'h01;
      end
      // quiet clock re-arms the frame
      // A rise after a quiet spell is already the first nibble
      if (idle_out && !rise) begin
        nib_reg  <= 4'h0;
        done_reg <= 1'b0;
      end else if (rise && !done_reg) begin
        nib_reg <= nib_reg + 4'h1;
        if (nib_reg == 4'h0) begin
          cmd_reg <= dat_s2_reg;
        end else if (nib_reg < 4'h3) begin
          addr_reg <= {addr_reg[3:0], dat_s2_reg};
        end else begin
          wdata_reg <= {wdata_reg[11:0], dat_s2_reg};
        end
        if (last) begin
          done_reg <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn || !link_en) begin
      exec_reg <= 1'b0;
    end else begin
      exec_reg <= last;
    end
  end

  // ==========================================================
  // Register decode
  // source bit map, top two zero
  // voltage flags merged in bit 0
  assign mirror = {2'b00, src_irq, |vlatch_reg};
  assign hit_mirror = (addr_reg == `DLI_MIRROR_LO) | (addr_reg == `DLI_MIRROR_HI);
  assign hit_volt = (addr_reg == `DLI_VOLT_OFF);
  assign wr_err = cmd_write(cmd_reg) & (hit_mirror | hit_volt);
  assign st = {1'b0, ~wr_err, wr_err, 1'b1};
  assign volt_clr = exec_reg & cmd_read(cmd_reg) & hit_volt;

  always_comb begin
    rd_val = per_rdata;
    if (hit_volt) begin
      rd_val = {11'h000, vlatch_reg};
    end else if (hit_mirror) begin
      // word at 0x00, bytes at 0x00/0x01
      if (cmd_word(cmd_reg)) begin
        rd_val = mirror;
      end else if (addr_reg == `DLI_MIRROR_HI) begin
        rd_val = {8'h00, mirror[15:8]};
      end else begin
        rd_val = {8'h00, mirror[7:0]};
      end
    end
  end

  assign per_wr = exec_reg & cmd_write(cmd_reg) & ~hit_mirror & ~hit_volt;
  assign per_rd = exec_reg & cmd_read(cmd_reg) & ~hit_mirror & ~hit_volt;
  assign per_addr = addr_reg;
  assign per_wdata = cmd_word(cmd_reg) ? wdata_reg : {8'h00, wdata_reg[7:0]};
  assign per_word = cmd_word(cmd_reg);

  // ==========================================================
  // Response shifter
  always_ff @(posedge clock) begin
    if (!rstn || !link_en) begin
      resp_reg  <= 24'h000000;
      left_reg  <= 4'h0;
      drive_reg <= 1'b0;
      out_reg   <= 4'h0;
    end else if (idle_out) begin
      left_reg  <= 4'h0;
      drive_reg <= 1'b0;
    end else if (exec_reg) begin
      left_reg <= rsp_nibs(cmd_reg);
      if (!cmd_read(cmd_reg)) begin
        resp_reg <= {st, 20'h00000};
      end else if (cmd_word(cmd_reg)) begin
        resp_reg <= {rd_val, st, 4'h0};
      end else begin
        resp_reg <= {rd_val[7:0], st, 12'h000};
      end
    end else if (fall) begin
      // data pins driven only while answering
      if (left_reg != 4'h0) begin
        out_reg   <= resp_reg[23:20];
        resp_reg  <= {resp_reg[19:0], 4'h0};
        left_reg  <= left_reg - 4'h1;
        drive_reg <= 1'b1;
      end else begin
        drive_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Voltage status latch
  always_ff @(posedge clock) begin
    if (!rstn) begin
      vcond_reg  <= `DLI_VOLT_RESET;
      vlatch_reg <= `DLI_VOLT_RESET;
    end else begin
      vcond_reg <= volt_cond;
      // new edge needed; set beats clear
      vlatch_reg <= (vlatch_reg & ~{5{volt_clr}}) | (volt_cond & ~vcond_reg);
    end
  end

  // ==========================================================
  // Wake and interrupt line
  always_ff @(posedge clock) begin
    if (!rstn) begin
      wake_reg    <= 1'b0;
      wake_ev_reg <= 1'b0;
    end else begin
      // wake command counts only in Stop
      wake_ev_reg <= exec_reg & (cmd_reg == DLI_CMD_WAKE) & (mode == DLI_STOP);
      if (die_wake && mode == DLI_STOP) begin
        wake_reg <= 1'b1;
      end else if (exec_reg && mode == DLI_NORMAL) begin
        wake_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      irq_reg <= 1'b0;
    end else begin
      unique case (mode)
        DLI_NORMAL: irq_reg <= (|mirror) | wake_reg;
        DLI_STOP:   irq_reg <= wake_reg;
        default:    irq_reg <= 1'b0;
      endcase
    end
  end

  assign link.link_irq_pin = irq_reg;
  assign link.tgt_data_out = out_reg;
  assign link.tgt_data_oe = drive_reg;
  assign wake_event = wake_ev_reg;

endmodule
`default_nettype wire

// >>> shared/dli_defines.svh
// Constants for the die link target and initiator.
// ==========================================================
// Overview of operation
// - Write: command, 8-bit address, then data.
// - Read: command, address, target returns data.
// - Target decodes a 256-byte register space.
// - Blocking read/write, non-blocking write; no non-blocking read.
// - Everything travels on 4 clocked data pins.
// - Target syncs itself from clock activity alone.
// - Target returns status, error and end acknowledge.
// - All target sources share one interrupt line.
// - Sleep disables link; data pins pulled low.
// - Stop: wake command detected; line wakes initiator.
// - Clock input, data bidirectional pulled low, irq output.
// - Irq high until acknowledged by link access.
// - Source interrupts asserted only in Normal mode; Stop raises wake only.
// - Read-only mirror shows every pending source.
// - Mirror read acknowledges nothing; module access clears. Any Normal-mode link access, mirror read included, clears the wake latch.
// - Mirror bit 0 ORs five voltage flags.
// - Mirror bits 1-13 mapped; bits 14-15 zero.
// - Mirror word at 0x00, bytes 0x00 and 0x01.
// - Initiator windows at 0x0200 blocking, 0x300 non-blocking.
// - Voltage irq acked by status read; recurrence re-raises.
`ifndef DLI_DEFINES_SVH
`define DLI_DEFINES_SVH

// ==========================================================
// Timing
`define DLI_CLK_PERIOD_NS  10
`define DLI_LINK_PERIOD_NS 160
`define DLI_HALF_CYC       ((`DLI_LINK_PERIOD_NS / 2) / `DLI_CLK_PERIOD_NS)
`define DLI_IDLE_CYC       6'h28
`define DLI_GAP_CYC        6'h30

// ==========================================================
// Target register offsets
`define DLI_MIRROR_LO      8'h00
`define DLI_MIRROR_HI      8'h01
`define DLI_VOLT_OFF       8'h04
`define DLI_VOLT_RESET     5'h00
`define DLI_MIRROR_RESET   16'h0000

// ==========================================================
// Status nibble fields
`define DLI_ST_END         0
`define DLI_ST_ERR         1
`define DLI_ST_OK          2

// ==========================================================
// Initiator APB map
`define DLI_CFG_OFF        12'h000
`define DLI_STAT_OFF       12'h004
`define DLI_BLK_WIN        4'h2
`define DLI_NB_WIN         4'h3
`define DLI_CFG_WORD       0
`define DLI_CFG_WAKE       1
`define DLI_STAT_BUSY      0
`define DLI_STAT_ERR       1
`define DLI_STAT_IRQ       2

`endif

// >>> shared/dli_if.sv
// Die link pins joining initiator and target.
`timescale 1ns/10ps
`default_nettype none
interface dli_if;
  logic       link_clock_pin;
  logic [3:0] ini_data_out;
  logic       ini_data_oe;
  logic [3:0] tgt_data_out;
  logic       tgt_data_oe;
  logic       link_irq_pin;
  logic [3:0] link_data_pins;

  // Permanent pull-down when neither end drives
  assign link_data_pins = tgt_data_oe ? tgt_data_out :
                          ini_data_oe ? ini_data_out : 4'h0;

  modport target (
    input  link_clock_pin,
    input  link_data_pins,
    output tgt_data_out,
    output tgt_data_oe,
    output link_irq_pin
  );

  modport initiator (
    output link_clock_pin,
    output ini_data_out,
    output ini_data_oe,
    input  link_data_pins,
    input  link_irq_pin
  );
endinterface
`default_nettype wire

// >>> shared/dli_pkg.sv
// Types and command decode shared by both link ends.
package dli_pkg;

  typedef enum logic [1:0] {
    DLI_NORMAL = 2'h0,
    DLI_STOP   = 2'h1,
    DLI_SLEEP  = 2'h2
  } dli_mode_t;

  typedef enum logic [3:0] {
    DLI_CMD_NONE   = 4'h0,
    DLI_CMD_WRB_BL = 4'h1,
    DLI_CMD_WRW_BL = 4'h2,
    DLI_CMD_WRB_NB = 4'h3,
    DLI_CMD_WRW_NB = 4'h4,
    DLI_CMD_RDB    = 4'h5,
    DLI_CMD_RDW    = 4'h6,
    DLI_CMD_WAKE   = 4'hF
  } dli_cmd_t;

  typedef enum logic [1:0] {
    DLI_ST_IDLE = 2'h0,
    DLI_ST_RUN  = 2'h1,
    DLI_ST_GAP  = 2'h2
  } dli_ini_state_t;

  function automatic logic cmd_write(input logic [3:0] c);
    return (c >= 4'h1) && (c <= 4'h4);
  endfunction

  function automatic logic cmd_read(input logic [3:0] c);
    return (c == 4'h5) || (c == 4'h6);
  endfunction

  function automatic logic cmd_word(input logic [3:0] c);
    return (c == 4'h2) || (c == 4'h4) || (c == 4'h6);
  endfunction

  function automatic logic cmd_block(input logic [3:0] c);
    return (c == 4'h1) || (c == 4'h2) || cmd_read(c);
  endfunction

  // Nibbles sent by the initiator: command, two address, data
  function automatic logic [3:0] req_nibs(input logic [3:0] c);
    if (cmd_write(c) || cmd_read(c)) begin
      return cmd_write(c) ? (cmd_word(c) ? 4'h7 : 4'h5) : 4'h3;
    end
    return 4'h1;
  endfunction

  // Nibbles returned by the target: data then one status nibble
  function automatic logic [3:0] rsp_nibs(input logic [3:0] c);
    if (cmd_read(c)) begin
      return cmd_word(c) ? 4'h5 : 4'h3;
    end
    return cmd_block(c) ? 4'h1 : 4'h0;
  endfunction

endpackage

// >>> verif/die_link_target_irq_bench.sv
// Self-checking bench joining both link ends.
`timescale 1ns/10ps
`default_nettype none
module die_link_target_irq_bench
  import dli_pkg::*;
;
  logic        clock, rstn, psel, penable, pwrite, pready, pslverr, irq_level;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic        erv, die_wake, wake_event, per_word, per_wr, per_rd;
  dli_mode_t   mode;
  logic [4:0]  volt_cond;
  logic [12:0] src_irq;
  logic [7:0]  per_addr;
  logic [15:0] per_wdata, per_rdata;
  logic [15:0] pmem [256];
  logic [7:0]  rd_addr;
  int          fails, checks_done;

  dli_if lnk ();
  dli_initiator u_dli_initiator (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(lnk.initiator), .irq_level(irq_level));
  dli_target u_dli_target (.clock(clock), .rstn(rstn), .mode(mode), .link(lnk.target),
    .volt_cond(volt_cond), .src_irq(src_irq), .die_wake(die_wake), .wake_event(wake_event),
    .per_addr(per_addr), .per_wdata(per_wdata), .per_word(per_word), .per_wr(per_wr),
    .per_rd(per_rd), .per_rdata(per_rdata));
  dli_properties u_dli_properties (.clock(clock), .rstn(rstn), .mode(mode),
    .link_clock_pin(lnk.link_clock_pin), .ini_data_oe(lnk.ini_data_oe),
    .tgt_data_oe(lnk.tgt_data_oe), .link_data_pins(lnk.link_data_pins),
    .link_irq_pin(lnk.link_irq_pin));

  // ==========================================================
  // Peripheral space behind the target
  always @(posedge clock) begin
    if (per_wr) begin
      pmem[per_addr] <= per_wdata;
    end
    if (per_rd) begin
      rd_addr <= per_addr;
    end
  end
  assign per_rdata = pmem[per_addr];

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ==========================================================
  // Helpers
  task automatic complete_run();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Blocking read waits behind a frame and its gap, so the bound is generous
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 3000);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 3000) begin
      fails++;
      complete_run();
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_mirror();
    src_irq <= 13'h1555;
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b0, 12'h200, 32'h0);
    chk(rdv & 32'hFFFF, 32'h2AAA);
    chk({31'h0, irq_level}, 32'h1);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b0, 12'h201, 32'h0);
    chk(rdv & 32'hFF, 32'h2A);
    apb(1'b0, 12'h200, 32'h0);
    chk(rdv & 32'hFF, 32'hAA);
    chk({31'h0, irq_level}, 32'h1);
    $display("t_mirror done");
  endtask

  task automatic t_volt();
    src_irq <= 13'h0000;
    volt_cond <= 5'h04;
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b0, 12'h200, 32'h0);
    chk(rdv & 32'hFFFF, 32'h1);
    apb(1'b0, 12'h204, 32'h0);
    chk(rdv & 32'hFFFF, 32'h4);
    apb(1'b0, 12'h200, 32'h0);
    chk(rdv & 32'hFFFF, 32'h0);
    idle(4);
    chk({31'h0, irq_level}, 32'h0);
    volt_cond <= 5'h00;
    idle(3);
    volt_cond <= 5'h1F;
    apb(1'b0, 12'h200, 32'h0);
    chk(rdv & 32'hFFFF, 32'h1);
    apb(1'b0, 12'h204, 32'h0);
    chk(rdv & 32'hFFFF, 32'h1F);
    volt_cond <= 5'h00;
    $display("t_volt done");
  endtask

  task automatic t_xfer();
    apb(1'b1, 12'h210, 32'hBEEF);
    chk({31'h0, erv}, 32'h0);
    chk({16'h0, pmem[8'h10]}, 32'hBEEF);
    apb(1'b0, 12'h210, 32'h0);
    chk(rdv & 32'hFFFF, 32'hBEEF);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h3FF, 32'h5A);
    chk({31'h0, erv}, 32'h0);
    apb(1'b0, 12'h2FF, 32'h0);
    chk(rdv & 32'hFF, 32'h5A);
    chk({24'h0, rd_addr}, 32'hFF);
    apb(1'b0, 12'h320, 32'h0);
    chk({31'h0, erv}, 32'h1);
    apb(1'b1, 12'h201, 32'h77);
    chk({31'h0, erv}, 32'h1);
    // Status: engine still in its gap, last error set, line low
    apb(1'b0, 12'h004, 32'h0);
    chk(rdv, 32'h3);
    apb(1'b1, 12'h100, 32'h0);
    chk({31'h0, erv}, 32'h1);
    $display("t_xfer done");
  endtask

  task automatic t_modes();
    int n;
    src_irq <= 13'h0100;
    mode <= DLI_SLEEP;
    idle(4);
    chk({31'h0, irq_level}, 32'h0);
    mode <= DLI_STOP;
    idle(4);
    chk({31'h0, irq_level}, 32'h0);
    // A wake write while the engine is busy is dropped, so wait for idle
    for (n = 0; n < 100; n++) begin
      apb(1'b0, 12'h004, 32'h0);
      if (rdv[0] == 1'b0) break;
    end
    apb(1'b1, 12'h000, 32'h2);
    for (n = 0; n < 800 && wake_event !== 1'b1; n++) @(posedge clock);
    chk({31'h0, wake_event}, 32'h1);
    if (n >= 800) complete_run();
    die_wake <= 1'b1;
    idle(6);
    chk({31'h0, irq_level}, 32'h1);
    die_wake <= 1'b0;
    src_irq <= 13'h0000;
    mode <= DLI_NORMAL;
    idle(4);
    chk({31'h0, irq_level}, 32'h1);
    apb(1'b0, 12'h200, 32'h0);
    idle(4);
    chk({31'h0, irq_level}, 32'h0);
    $display("t_modes done");
  endtask

  initial begin
    fails = 0;
    checks_done = 0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    mode = DLI_NORMAL;
    volt_cond = 5'h00;
    src_irq = 13'h0000;
    die_wake = 1'b0;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    t_mirror();
    t_volt();
    t_xfer();
    t_modes();
    complete_run();
  end
endmodule
`default_nettype wire

// >>> verif/dli_properties.sv
// Pin checker for the die link, placed beside the interface.
`timescale 1ns/10ps
`default_nettype none
module dli_properties
  import dli_pkg::*;
(
  // System
  input wire logic       clock,
  input wire logic       rstn,
  input wire dli_mode_t  mode,
  // Link pins
  input wire logic       link_clock_pin,
  input wire logic       ini_data_oe,
  input wire logic       tgt_data_oe,
  input wire logic [3:0] link_data_pins,
  input wire logic       link_irq_pin
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  // ==========================================================
  // Data wire
  chk_single_driver: assert property (!(ini_data_oe && tgt_data_oe))
    else $error("both ends drive the data pins");
  chk_pull_down: assert property (!ini_data_oe && !tgt_data_oe |->
    link_data_pins == 4'h0)
    else $error("released data pins not low");
  chk_nibble_setup: assert property ($rose(link_clock_pin) |-> $stable(link_data_pins))
    else $error("data moved at a link clock rise");

  // ==========================================================
  // Link clock, eight system cycles per half period
  chk_clock_high: assert property ($rose(link_clock_pin) |->
    link_clock_pin[*8] ##1 !link_clock_pin)
    else $error("link clock high phase wrong");
  chk_clock_low: assert property ($fell(link_clock_pin) |-> !link_clock_pin[*8])
    else $error("link clock low phase too short");

  // ==========================================================
  // Target answer
  chk_turnaround: assert property ($rose(tgt_data_oe) |-> !link_clock_pin && !ini_data_oe)
    else $error("target drove before turnaround");
  chk_status_stands: assert property ($rose(tgt_data_oe) |=>
    (tgt_data_oe && $stable(link_data_pins))[*8])
    else $error("target nibble did not stand");
  chk_release_low: assert property ($fell(tgt_data_oe) |-> !link_clock_pin)
    else $error("target released with clock high");

  // ==========================================================
  // Sleep keeps the link and the line quiet
  chk_sleep_quiet: assert property (mode == DLI_SLEEP && $past(mode) == DLI_SLEEP
    |-> !tgt_data_oe && !link_irq_pin)
    else $error("activity while asleep");

  cov_answer: cover property ($rose(tgt_data_oe));
  cov_irq: cover property ($rose(link_irq_pin));
  cov_stop_wake: cover property (mode == DLI_STOP && $rose(link_irq_pin));
endmodule
`default_nettype wire
